/* File: maf_filter.sv */
// Moving-average filter over the last N readings with a serial divider
`timescale 1ns/1ns
`default_nettype none
module maf_filter #(
   parameter int DW = 16,
   parameter int LW = 7,
   parameter int DEPTH = 64
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Reading in
   input wire logic push,
   input wire logic [DW-1:0] din,
   input wire logic [LW-1:0] len,
   // Average out
   output logic avg_valid,
   output logic [DW-1:0] avg
);
   localparam int AW = $clog2(DEPTH);
   localparam int SW = DW + AW;
   localparam logic [4:0] DIV_STEPS = 5'(SW);

   typedef struct packed {
      maf_pkg::maf_fstate_t st;
      logic [AW-1:0] wp;
      logic [LW-1:0] fill;
      logic [LW-1:0] plen;
      logic [SW-1:0] sum;
      logic [SW-1:0] quo;
      logic [LW:0] rem;
      logic [LW-1:0] dvs;
      logic [4:0] cnt;
      logic vld;
      logic [DW-1:0] avg;
   } maf_filt_st_t;

   maf_filt_st_t s_ff, nxt_s;
   logic [DW-1:0] mem [DEPTH];
   logic [DW-1:0] oldest;
   logic [LW-1:0] base_fill;
   logic [SW-1:0] base_sum;
   logic [LW:0] r2;

   // Oldest reading of the window; len of 64 wraps onto the slot being replaced
   assign oldest = mem[s_ff.wp - len[AW-1:0]];

   // Window bookkeeping, then one quotient bit per cycle
   always_comb begin
      nxt_s = s_ff;
      nxt_s.vld = 1'b0;
      base_fill = (len != s_ff.plen) ? '0 : s_ff.fill;
      base_sum = (len != s_ff.plen) ? '0 : s_ff.sum;
      r2 = {s_ff.rem[LW-1:0], s_ff.quo[SW-1]};
      unique case (s_ff.st)
         maf_pkg::FS_IDLE: begin
            // Pushes while dividing are dropped; readings are far apart
            if (push) begin
               nxt_s.plen = len;
               nxt_s.wp = s_ff.wp + 1'b1;
               nxt_s.sum = base_sum + SW'(din) - ((base_fill == len) ? SW'(oldest) : '0);
               nxt_s.fill = (base_fill == len) ? len : base_fill + 1'b1;
               nxt_s.quo = nxt_s.sum;
               nxt_s.dvs = nxt_s.fill;
               nxt_s.rem = '0;
               nxt_s.cnt = DIV_STEPS;
               nxt_s.st = maf_pkg::FS_DIV;
            end
         end
         maf_pkg::FS_DIV: begin
            nxt_s.rem = (r2 >= {1'b0, s_ff.dvs}) ? r2 - {1'b0, s_ff.dvs} : r2;
            nxt_s.quo = {s_ff.quo[SW-2:0], r2 >= {1'b0, s_ff.dvs}};
            nxt_s.cnt = s_ff.cnt - 1'b1;
            if (s_ff.cnt == 5'h01) begin
               nxt_s.vld = 1'b1;
               nxt_s.avg = nxt_s.quo[DW-1:0];
               nxt_s.st = maf_pkg::FS_IDLE;
            end
         end
      endcase
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_ff <= '{st: maf_pkg::FS_IDLE, plen: maf_pkg::FLEN_RST, default: '0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   // Reading store; no reset needed, the fill count guards stale words
   always_ff @(posedge pclk) begin
      if (s_ff.st == maf_pkg::FS_IDLE && push) begin
         mem[s_ff.wp] <= din;
      end
   end

   assign avg_valid = s_ff.vld;
   assign avg = s_ff.avg;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_take;
      s_ff.st == maf_pkg::FS_IDLE && push;
   endsequence
   avg_follows_a: assert property (
      s_take |-> ##[23:23] s_ff.vld) else $error("average not produced after reading");
endmodule // maf_filter
`default_nettype wire

/* File: maf_pkg.sv */
// Shared constants and types for the measurement alarm filter block
`default_nettype none
package maf_pkg;
   // Register byte offsets on the APB
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_FLEN = 8'h04;
   localparam logic [7:0] OFF_CFG [2] = '{8'h08, 8'h14};
   localparam logic [7:0] OFF_LVL [2] = '{8'h0C, 8'h18};
   localparam logic [7:0] OFF_HYST [2] = '{8'h10, 8'h1C};
   localparam logic [7:0] OFF_STAT = 8'h20;
   localparam logic [7:0] OFF_CAPT [2] = '{8'h24, 8'h28};
   localparam logic [7:0] OFF_FILT = 8'h2C;
   localparam logic [7:0] OFF_ISTA = 8'h30;
   localparam logic [7:0] OFF_IMSK = 8'h34;
   // Field positions
   localparam int CTRL_CAL_BIT = 0;
   localparam int CTRL_UNL_BIT = 1;
   localparam int CFG_LATCH_BIT = 2;
   localparam int CFG_FOLLOW_BIT = 3;
   localparam int ISTA_UPD_BIT = 2;
   // Filter length limits and value after reset
   localparam logic [6:0] FLEN_RST = 7'h08;
   localparam logic [6:0] FLEN_MIN = 7'h01;
   localparam logic [6:0] FLEN_MAX = 7'h40;
   // Timing: clock rate, update rate, LED half period
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned UPD_PER_SEC = 5;
   localparam int unsigned UPD_CYC = CLK_HZ / UPD_PER_SEC;
   localparam int unsigned FLASH_HALF_MS = 500;
   localparam int unsigned FLASH_CYC = (CLK_HZ / 1000) * FLASH_HALF_MS;
   // Alarm modes; code 2'b11 is illegal and taken as unused
   typedef enum logic [1:0] {
      MODE_NONE = 2'h0,
      MODE_LOW = 2'h1,
      MODE_HIGH = 2'h2
   } maf_mode_t;
   // Filter engine states
   typedef enum logic [1:0] {
      FS_IDLE = 2'h1,
      FS_DIV = 2'h2
   } maf_fstate_t;
endpackage
`default_nettype wire

/* File: maf_top.sv */
// Two measurement alarms on a filtered reading, with APB registers and interrupt
`timescale 1ns/1ns
`default_nettype none
module maf_top #(
   parameter int DW = 16,
   parameter int unsigned UPD_CYC = maf_pkg::UPD_CYC,
   parameter int unsigned FLASH_CYC = maf_pkg::FLASH_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Transducer readings, same clock
   input wire logic sample_valid,
   input wire logic [DW-1:0] sample_data,
   // Alarm outputs
   output logic [1:0] alarm_relay,
   output logic [1:0] alarm_ind,
   output logic alarm_led,
   output logic irq
);
   typedef struct packed {
      logic rdy;
      logic err;
      logic [31:0] rdata;
      logic cal;
      logic unl;
      logic [6:0] flen;
      maf_pkg::maf_mode_t [1:0] mode;
      logic [1:0] latch;
      logic [1:0] follow;
      logic [1:0][DW-1:0] lvl;
      logic [1:0][DW-1:0] hyst;
      logic [1:0][DW-1:0] capt;
      logic [1:0] act;
      logic [1:0] dir;
      logic [DW-1:0] raw;
      logic tick;
      logic [31:0] upd_cnt;
      logic [31:0] fl_cnt;
      logic led;
      logic [2:0] ista;
      logic [2:0] imsk;
      logic irq;
   } maf_top_st_t;

   maf_top_st_t s_ff, nxt_s;
   logic avg_valid;
   logic [DW-1:0] avg;
   logic hit;
   logic wr;
   logic [31:0] rd;
   logic [2:0] ev;
   logic [2:0] w1c;
   // Last filtered value, held for status reads
   logic [DW-1:0] filt_ff;

   // Activation test on one reading
   function automatic logic trig_f(input maf_pkg::maf_mode_t m, input logic [DW-1:0] v,
                                   input logic [DW-1:0] l);
      trig_f = (m == maf_pkg::MODE_LOW && v < l) || (m == maf_pkg::MODE_HIGH && v > l);
   endfunction

   // Release test; sums are one bit wider so level plus hysteresis cannot wrap
   function automatic logic clr_f(input maf_pkg::maf_mode_t m, input logic [DW-1:0] v,
                                  input logic [DW-1:0] l, input logic [DW-1:0] h);
      logic [DW:0] up;
      up = {1'b0, l} + {1'b0, h};
      clr_f = (m == maf_pkg::MODE_LOW && {1'b0, v} > up) ||
              (m == maf_pkg::MODE_HIGH && {1'b0, v} + {1'b0, h} < {1'b0, l});
   endfunction

   // Filter length written by software, held inside 1..64
   function automatic logic [6:0] clamp_f(input logic [31:0] d);
      if (d < 32'(maf_pkg::FLEN_MIN)) begin
         clamp_f = maf_pkg::FLEN_MIN;
      end else if (d > 32'(maf_pkg::FLEN_MAX)) begin
         clamp_f = maf_pkg::FLEN_MAX;
      end else begin
         clamp_f = d[6:0];
      end
   endfunction

   // Mode field; the illegal code is taken as unused
   function automatic maf_pkg::maf_mode_t mode_f(input logic [1:0] d);
      mode_f = (d == 2'h3) ? maf_pkg::MODE_NONE : maf_pkg::maf_mode_t'(d);
   endfunction

   maf_filter #(
      .DW(DW),
      .LW(7),
      .DEPTH(64)
   ) u_filter (
      .pclk(pclk),
      .presetn(presetn),
      .push(s_ff.tick),
      .din(s_ff.raw),
      .len(s_ff.flen),
      .avg_valid(avg_valid),
      .avg(avg)
   );

   // Address decode and read data
   always_comb begin
      hit = 1'b1;
      rd = '0;
      unique case (paddr)
         maf_pkg::OFF_CTRL: rd[maf_pkg::CTRL_CAL_BIT] = s_ff.cal;
         maf_pkg::OFF_FLEN: rd[6:0] = s_ff.flen;
         maf_pkg::OFF_STAT: rd[3:0] = {s_ff.dir, s_ff.act};
         maf_pkg::OFF_FILT: rd[DW-1:0] = filt_ff;
         maf_pkg::OFF_ISTA: rd[2:0] = s_ff.ista;
         maf_pkg::OFF_IMSK: rd[2:0] = s_ff.imsk;
         default: hit = 1'b0;
      endcase
      for (int i = 0; i < 2; i++) begin
         if (paddr == maf_pkg::OFF_CFG[i]) begin
            hit = 1'b1;
            rd[3:0] = {s_ff.follow[i], s_ff.latch[i], s_ff.mode[i]};
         end
         if (paddr == maf_pkg::OFF_LVL[i]) begin
            hit = 1'b1;
            rd[DW-1:0] = s_ff.lvl[i];
         end
         if (paddr == maf_pkg::OFF_HYST[i]) begin
            hit = 1'b1;
            rd[DW-1:0] = s_ff.hyst[i];
         end
         // Captured reading reads zero while the alarm is inactive
         if (paddr == maf_pkg::OFF_CAPT[i]) begin
            hit = 1'b1;
            rd[DW-1:0] = s_ff.act[i] ? s_ff.capt[i] : '0;
         end
      end
   end

   // Filtered value register, updated on every new average
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filt_ff <= '0;
      end else if (avg_valid) begin
         filt_ff <= avg;
      end
   end

   // Bus handshake, register writes, alarm evaluation, LED and interrupt
   always_comb begin
      nxt_s = s_ff;
      nxt_s.unl = 1'b0;
      wr = 1'b0;
      w1c = '0;
      ev = '0;
      // One wait state: read data and error are registered together with pready
      if (psel && penable && !s_ff.rdy) begin
         nxt_s.rdy = 1'b1;
         nxt_s.rdata = hit ? rd : '0;
         nxt_s.err = !hit;
      end else if (s_ff.rdy) begin
         nxt_s.rdy = 1'b0;
         nxt_s.err = 1'b0;
         nxt_s.rdata = '0;
         wr = psel && penable && pwrite && hit;
      end
      if (wr) begin
         if (paddr == maf_pkg::OFF_CTRL) begin
            nxt_s.cal = pwdata[maf_pkg::CTRL_CAL_BIT];
            nxt_s.unl = pwdata[maf_pkg::CTRL_UNL_BIT];
         end
         if (paddr == maf_pkg::OFF_FLEN) nxt_s.flen = clamp_f(pwdata);
         if (paddr == maf_pkg::OFF_ISTA) w1c = pwdata[2:0];
         if (paddr == maf_pkg::OFF_IMSK) nxt_s.imsk = pwdata[2:0];
         for (int i = 0; i < 2; i++) begin
            if (paddr == maf_pkg::OFF_CFG[i]) begin
               nxt_s.mode[i] = mode_f(pwdata[1:0]);
               nxt_s.latch[i] = pwdata[maf_pkg::CFG_LATCH_BIT];
               nxt_s.follow[i] = pwdata[maf_pkg::CFG_FOLLOW_BIT];
            end
            if (paddr == maf_pkg::OFF_LVL[i]) nxt_s.lvl[i] = pwdata[DW-1:0];
            if (paddr == maf_pkg::OFF_HYST[i]) nxt_s.hyst[i] = pwdata[DW-1:0];
         end
      end
      // Each alarm is judged only on a new filtered value
      for (int i = 0; i < 2; i++) begin
         if (s_ff.unl && s_ff.latch[i]) begin
            nxt_s.act[i] = 1'b0;
         end
         if (avg_valid) begin
            if (s_ff.act[i]) begin
               // Latching alarms ignore the release test entirely
               if (!s_ff.latch[i] && clr_f(s_ff.mode[i], avg, s_ff.lvl[i], s_ff.hyst[i])) begin
                  nxt_s.act[i] = 1'b0;
               end
            end else if (trig_f(s_ff.mode[i], avg, s_ff.lvl[i]) &&
                         (s_ff.follow[i] || !s_ff.cal)) begin
               nxt_s.act[i] = 1'b1;
               nxt_s.capt[i] = avg;
               nxt_s.dir[i] = (s_ff.mode[i] == maf_pkg::MODE_HIGH);
               ev[i] = 1'b1;
            end
         end
         if (nxt_s.mode[i] == maf_pkg::MODE_NONE) begin
            nxt_s.act[i] = 1'b0;
         end
      end
      ev[maf_pkg::ISTA_UPD_BIT] = avg_valid;
      // Set wins over a clear written in the same cycle
      nxt_s.ista = (s_ff.ista & ~w1c) | ev;
      nxt_s.irq = |(nxt_s.ista & nxt_s.imsk);
      // Latest transducer reading, taken into the filter at the update rate
      if (sample_valid) nxt_s.raw = sample_data;
      if (s_ff.upd_cnt == 32'(UPD_CYC - 1)) begin
         nxt_s.upd_cnt = '0;
         nxt_s.tick = 1'b1;
      end else begin
         nxt_s.upd_cnt = s_ff.upd_cnt + 32'h0000_0001;
         nxt_s.tick = 1'b0;
      end
      // Counter parks at the wrap value so the LED turns on in the same cycle as activation
      if (nxt_s.act == 2'h0) begin
         nxt_s.led = 1'b0;
         nxt_s.fl_cnt = 32'(FLASH_CYC - 1);
      end else if (s_ff.fl_cnt == 32'(FLASH_CYC - 1)) begin
         nxt_s.led = !s_ff.led;
         nxt_s.fl_cnt = '0;
      end else begin
         nxt_s.fl_cnt = s_ff.fl_cnt + 32'h0000_0001;
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_ff <= '{flen: maf_pkg::FLEN_RST, mode: {maf_pkg::MODE_NONE, maf_pkg::MODE_NONE},
                   fl_cnt: 32'(FLASH_CYC - 1), default: '0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   // Outputs straight from the state register
   assign prdata = s_ff.rdata;
   assign pready = s_ff.rdy;
   assign pslverr = s_ff.err;
   assign alarm_relay = s_ff.act;
   assign alarm_ind = s_ff.act;
   assign alarm_led = s_ff.led;
   assign irq = s_ff.irq;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_low_trip;
      avg_valid && !s_ff.act[0] && s_ff.mode[0] == maf_pkg::MODE_LOW && avg < s_ff.lvl[0] &&
      (s_ff.follow[0] || !s_ff.cal) && nxt_s.mode[0] == maf_pkg::MODE_LOW;
   endsequence
   sequence s_high_trip;
      avg_valid && !s_ff.act[1] && s_ff.mode[1] == maf_pkg::MODE_HIGH && avg > s_ff.lvl[1] &&
      (s_ff.follow[1] || !s_ff.cal) && nxt_s.mode[1] == maf_pkg::MODE_HIGH;
   endsequence

   none_idle_a: assert property (
      s_ff.mode[0] == maf_pkg::MODE_NONE |-> !s_ff.act[0]) else $error("unused alarm active");
   low_trip_a: assert property (
      s_low_trip |=> s_ff.act[0] && s_ff.capt[0] == $past(avg) && !s_ff.dir[0])
      else $error("low alarm missed");
   high_trip_a: assert property (
      s_high_trip |=> s_ff.act[1] && s_ff.dir[1] && alarm_relay[1]) else $error("high alarm missed");
   cal_inhibit_a: assert property (
      s_ff.cal && !s_ff.follow[0] && !s_ff.act[0] |=> !s_ff.act[0]) else $error("alarm during cal");
   rise_flag_a: assert property (
      $rose(s_ff.act[0]) |-> s_ff.ista[0] && alarm_ind[0]) else $error("activation not flagged");
   led_flash_a: assert property (
      $rose(alarm_led) |-> (alarm_led || s_ff.act == 2'h0)[*8]) else $error("LED half period too short");
   led_off_a: assert property (
      s_ff.act == 2'h0 |-> !alarm_led) else $error("LED on with no alarm");
   latch_hold_a: assert property (
      s_ff.act[0] && s_ff.latch[0] && nxt_s.latch[0] && !s_ff.unl &&
      nxt_s.mode[0] != maf_pkg::MODE_NONE |=> s_ff.act[0]) else $error("latched alarm dropped");
   unlatch_clr_a: assert property (
      s_ff.unl && !avg_valid && s_ff.latch == 2'h3 |=> s_ff.act == 2'h0) else $error("unlatch failed");
   low_hyst_a: assert property (
      avg_valid && s_ff.act[0] && s_ff.mode[0] == maf_pkg::MODE_LOW && !s_ff.unl &&
      {1'b0, avg} <= {1'b0, s_ff.lvl[0]} + {1'b0, s_ff.hyst[0]} &&
      nxt_s.mode[0] == maf_pkg::MODE_LOW |=> s_ff.act[0]) else $error("low alarm released early");
   tick_gap_a: assert property (
      s_ff.tick |=> !s_ff.tick[*2]) else $error("update ticks too close");
endmodule // maf_top
`default_nettype wire

/* File: maf_xdcr.sv */
// Transducer model: periodic readings handed to the alarm block
`timescale 1ns/1ns
`default_nettype none
module maf_xdcr #(
   parameter int PER = 8
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Reading wanted by the bench
   input wire logic [15:0] level_in,
   // Reading out
   output logic sample_valid,
   output logic [15:0] sample_data
);
   int cnt;
   // One pulse per period; data is not held between pulses, so it flips every cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 0;
         sample_valid <= 1'b0;
         sample_data <= 16'h0000;
      end else begin
         cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
         sample_valid <= (cnt == 0);
         sample_data <= (cnt == 0) ? level_in : ~sample_data;
      end
   end
endmodule // maf_xdcr
`default_nettype wire

/* File: tb_measurement_alarm_filter.sv */
// Self-checking bench for the two-alarm filtered measurement block
`timescale 1ns/1ns
`default_nettype none
module tb_measurement_alarm_filter;
   localparam int UPD = 200;
   localparam int FL = 8;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic sample_valid;
   logic [15:0] sample_data;
   logic [15:0] raw = 16'h0000;
   logic [1:0] alarm_relay;
   logic [1:0] alarm_ind;
   logic alarm_led;
   logic irq;
   logic [31:0] seed = 32'h0001_74B5;
   logic [31:0] rdat;
   logic rerr;
   int n_errors = 0;
   int checked = 0;
   int cycles = 0;
   // Reference model state, one entry per alarm
   int act[2], capt[2], dir[2], mode[2], lvl[2], hys[2], lat[2], fol[2];
   int cal = 0;
   int flen = 1;
   int cur = 0;
   int avg = 0;
   int win[$];
   int seq_a[5] = '{100, 99, 110, 111, 20};

   maf_top #(.DW(16), .UPD_CYC(UPD), .FLASH_CYC(FL)) uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sample_valid(sample_valid), .sample_data(sample_data), .alarm_relay(alarm_relay),
      .alarm_ind(alarm_ind), .alarm_led(alarm_led), .irq(irq));
   maf_xdcr #(.PER(8)) xdcr (.pclk(pclk), .presetn(presetn), .level_in(raw), .sample_valid(sample_valid),
      .sample_data(sample_data));

   // 100 MHz clock
   always #5 pclk = ~pclk;

   // Hang guard: the whole run needs well under this many cycles
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         n_errors++;
         summarize();
      end
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic int xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return int'(seed % 1000);
   endfunction

   // APB transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) chk("pready", 1, pready);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0000_0000);
   endtask

   // One filtered update: window of the last flen readings, then both alarms
   function automatic void push(input int v);
      int s;
      win.push_back(v);
      if (win.size() > flen) void'(win.pop_front());
      s = 0;
      foreach (win[k]) s += win[k];
      avg = s / win.size();
      for (int i = 0; i < 2; i++) begin
         if (mode[i] == 0) begin
            act[i] = 0;
         end else if (act[i] == 0) begin
            if (((mode[i] == 1 && avg < lvl[i]) || (mode[i] == 2 && avg > lvl[i])) && (cal == 0 || fol[i] == 1)) begin
               act[i] = 1;
               capt[i] = avg;
               dir[i] = mode[i] - 1;
            end
         end else if (lat[i] == 0 && ((mode[i] == 1 && avg > lvl[i] + hys[i]) || (mode[i] == 2 && avg < lvl[i] - hys[i]))) begin
            act[i] = 0;
         end
      end
   endfunction

   // Poll for a fresh filtered value, acknowledge it, advance the model
   task automatic wait_upd();
      int n;
      n = 0;
      do begin
         rd(maf_pkg::OFF_ISTA);
         n++;
      end while (rdat[2] !== 1'b1 && n < 100);
      chk("update", 1, rdat[2]);
      wr(maf_pkg::OFF_ISTA, 32'h0000_0004);
      push(cur);
   endtask

   task automatic verify();
      int on;
      int tg;
      logic prev;
      rd(maf_pkg::OFF_STAT);
      chk("status", act[0] + 2 * act[1] + 4 * dir[0] + 8 * dir[1], rdat);
      for (int i = 0; i < 2; i++) begin
         rd(maf_pkg::OFF_CAPT[i]);
         chk("capture", act[i] ? capt[i] : 0, rdat);
      end
      rd(maf_pkg::OFF_FILT);
      chk("filtered", avg, rdat);
      chk("relay", act[0] + 2 * act[1], alarm_relay);
      chk("indicator", act[0] + 2 * act[1], alarm_ind);
      on = 0;
      tg = 0;
      prev = alarm_led;
      repeat (4 * FL) begin
         @(posedge pclk);
         on += alarm_led;
         tg += (alarm_led != prev);
         prev = alarm_led;
      end
      chk("led flashing", act[0] | act[1], tg >= 3 && tg <= 5);
      if ((act[0] | act[1]) == 0) chk("led idle", 0, on);
   endtask

   task automatic step(input int v);
      raw <= v[15:0];
      cur = v;
      wait_upd();
      verify();
   endtask

   // Reconfigure one alarm; unused first so no half-written setting is evaluated
   task automatic cfg(input int i, input int m, input int l, input int h, input int la, input int fo);
      wr(maf_pkg::OFF_CFG[i], 32'h0000_0000);
      act[i] = 0;
      mode[i] = 0;
      repeat (2) @(posedge pclk);
      chk("cleared", 0, alarm_relay[i]);
      lvl[i] = l;
      hys[i] = h;
      lat[i] = la;
      fol[i] = fo;
      wr(maf_pkg::OFF_LVL[i], l);
      wr(maf_pkg::OFF_HYST[i], h);
      wr(maf_pkg::OFF_CFG[i], m + 4 * la + 8 * fo);
      mode[i] = m;
      wait_upd();
   endtask

   task automatic irq_is(input logic e);
      repeat (2) @(posedge pclk);
      chk("irq", e, irq);
   endtask

   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(maf_pkg::OFF_FLEN);
      chk("flen reset", 8, rdat);
      rd(maf_pkg::OFF_IMSK);
      chk("mask reset", 0, rdat);
      rd(8'h3C);
      chk("unmapped error", 1, rerr);
      chk("unmapped data", 0, rdat);
      wr(maf_pkg::OFF_FLEN, 32'h0000_0000);
      rd(maf_pkg::OFF_FLEN);
      chk("flen low clamp", 1, rdat);
      wr(maf_pkg::OFF_FLEN, 32'h0000_0064);
      rd(maf_pkg::OFF_FLEN);
      chk("flen high clamp", 64, rdat);
      wr(maf_pkg::OFF_FLEN, 32'h0000_0001);
      wait_upd();
      wait_upd();
      $display("test registers done");
      // Low alarm edges and hysteresis while the unused alarm sees readings below its level
      cfg(0, 1, 100, 10, 0, 0);
      cfg(1, 0, 150, 0, 0, 0);
      foreach (seq_a[k]) step(seq_a[k]);
      // Latching high alarm, then both latched and unlatched together
      cfg(0, 0, 0, 0, 0, 0);
      cfg(1, 2, 200, 20, 1, 0);
      step(200);
      step(201);
      step(150);
      cfg(0, 1, 300, 0, 1, 0);
      step(250);
      wr(maf_pkg::OFF_CTRL, 32'h0000_0002);
      act[0] = 0;
      act[1] = 0;
      irq_is(1'b0);
      chk("unlatch", 0, alarm_relay);
      step(250);
      cfg(1, 2, 200, 20, 0, 0);
      step(201);
      step(180);
      step(179);
      $display("test thresholds done");
      // Calibration: only the following alarm may trip
      wr(maf_pkg::OFF_CTRL, 32'h0000_0001);
      cal = 1;
      rd(maf_pkg::OFF_CTRL);
      chk("ctrl", 1, rdat);
      cfg(0, 1, 300, 0, 0, 0);
      cfg(1, 2, 200, 0, 0, 1);
      step(250);
      wr(maf_pkg::OFF_CTRL, 32'h0000_0000);
      cal = 0;
      step(250);
      $display("test calibration done");
      // Interrupt raised, masked and cleared
      wr(maf_pkg::OFF_ISTA, 32'h0000_0003);
      wr(maf_pkg::OFF_IMSK, 32'h0000_0001);
      irq_is(1'b0);
      cfg(0, 1, 500, 0, 0, 0);
      irq_is(1'b1);
      wr(maf_pkg::OFF_IMSK, 32'h0000_0000);
      irq_is(1'b0);
      wr(maf_pkg::OFF_IMSK, 32'h0000_0001);
      irq_is(1'b1);
      wr(maf_pkg::OFF_ISTA, 32'h0000_0001);
      irq_is(1'b0);
      wr(maf_pkg::OFF_IMSK, 32'h0000_0000);
      $display("test interrupt done");
      // Averaging window of four with random readings
      cfg(0, 1, 400, 50, 0, 0);
      cfg(1, 2, 600, 100, 1, 0);
      wr(maf_pkg::OFF_FLEN, 32'h0000_0004);
      flen = 4;
      win.delete();
      repeat (12) step(xs());
      $display("test filter done");
      summarize();
   end
endmodule // tb_measurement_alarm_filter
`default_nettype wire
